// *** verilog/pio_port_io.sv ***
// Function
// - cfg/data pairs select hi-z, pull-up, low, high
// - ports l, g, c: config, data, pin read locations
// - every bit configured independently, except g1, g6, g7 pads (fixed uses)
// - port g data bit 7 requests halt
// - port g data bit 6 requests idle
// - port g config bit 6 selects alternate clock phase
// - g7 config enables halt start-up delay (rc)
// - port g data bits 6,7 read zero
// - rc option: g7 input, rising edge exits halt
// - crystal option: g7 drives oscillator clock out
// - g1 error output; g6 input only
// - port g alternate functions routed to pins
// - port l alternate functions routed to pins
// - all port l pins feed wake-up
// - port i input only, comparator pins
// - port d output, high during reset
// - reset clears l, g, c registers
`timescale 1ns/10ps
module pio_port_io
    import pio_pkg::*;
(
    input wire logic clk, // instruction clock
    input wire logic reset, // synchronous active-high reset
    input wire logic [7:0] avs_address, // byte address
    input wire logic avs_read, // read strobe
    input wire logic avs_write, // write strobe
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic [7:0] l_pin_in, // port l pin levels
    output logic [7:0] l_pin_out, // port l drive value
    output logic [7:0] l_pin_oe, // port l drive enable
    output logic [7:0] l_pin_pull, // port l weak pull-up
    input wire logic [7:0] g_pin_in, // port g pin levels
    output logic [7:0] g_pin_out, // port g drive value
    output logic [7:0] g_pin_oe, // port g drive enable
    output logic [7:0] g_pin_pull, // port g weak pull-up
    input wire logic [7:0] c_pin_in, // port c pin levels
    output logic [7:0] c_pin_out, // port c drive value
    output logic [7:0] c_pin_oe, // port c drive enable
    output logic [7:0] c_pin_pull, // port c weak pull-up
    input wire logic [7:0] i_pin_in, // port i pin levels
    output logic [7:0] d_pin_out, // port d outputs
    input wire logic crystal_option, // 1 crystal, 0 rc oscillator
    input wire logic oscillator_clock_in, // buffered oscillator clock
    input wire logic supervision_error, // error from supervision timer
    output logic halt_request, // one-cycle halt request
    output logic idle_request, // one-cycle idle request
    output logic halt_exit_wakeup, // one-cycle g7 rising edge
    output logic halt_startup_delay_enable, // start-up delay active
    output logic serial_alt_phase, // alternate shift clock phase
    output logic serial_data_in, // serial data input
    output logic serial_shift_clock_in, // shift clock from pin
    input wire logic serial_shift_clock_out, // shift clock to pin
    input wire logic serial_shift_clock_oe, // shift clock drive enable
    input wire logic serial_data_out, // serial data output
    input wire logic serial_data_out_en, // serial data routing
    input wire logic timer1_io_out, // timer 1 output
    input wire logic timer1_io_en, // timer 1 output routing
    output logic timer1_io, // timer 1 input from pin
    output logic timer1_capture_in, // timer 1 capture
    output logic external_interrupt_in, // external interrupt
    output logic usart_external_clock, // usart clock from pin
    input wire logic usart_transmit_pin, // usart transmit data
    input wire logic usart_transmit_en, // usart transmit routing
    output logic usart_receive_pin, // usart receive data
    output logic timer2_input_a, // timer 2 input a
    output logic timer2_input_b, // timer 2 input b
    output logic timer3_input_a, // timer 3 input a
    output logic timer3_input_b, // timer 3 input b
    output logic [7:0] multi_input_wakeup, // wake-up sources
    output logic comparator1_negative_input, // comparator 1 -in
    output logic comparator1_positive_input, // comparator 1 +in
    output logic comparator1_output, // comparator 1 out
    output logic comparator2_negative_input, // comparator 2 -in
    output logic comparator2_positive_input, // comparator 2 +in
    output logic comparator2_output // comparator 2 out
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    pio_port_regs_t l_r, l_nxt, g_r, g_nxt, c_r, c_nxt;
    logic [7:0] d_r, d_nxt;
    logic halt_r, halt_nxt, idle_r, idle_nxt;
    logic wake_r, wake_nxt, g7_prev_r, g7_prev_nxt;
    pio_bus_state_t st_r, st_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [7:0] l_sync, g_sync, c_sync, i_sync;
    pio_pad_t l_pad, g_pad, c_pad;
    logic wr_hit;
    logic [7:0] wdata;

    // merge an enabled low byte into a stored value
    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] nv, input logic en);
        merge_byte = en ? nv : old;
    endfunction : merge_byte

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    pio_sync2 u_sync_l (.clk(clk), .reset(reset), .d(l_pin_in), .q(l_sync));
    pio_sync2 u_sync_g (.clk(clk), .reset(reset), .d(g_pin_in), .q(g_sync));
    pio_sync2 u_sync_c (.clk(clk), .reset(reset), .d(c_pin_in), .q(c_sync));
    pio_sync2 u_sync_i (.clk(clk), .reset(reset), .d(i_pin_in), .q(i_sync));

    // ------------------------------------------------------------
    // pad decode
    // ------------------------------------------------------------
    pio_pad_decode u_dec_l (.regs(l_r), .pad(l_pad));
    pio_pad_decode u_dec_g (.regs(g_r), .pad(g_pad));
    pio_pad_decode u_dec_c (.regs(c_r), .pad(c_pad));

    // ------------------------------------------------------------
    // bus handshake: two wait cycles, answer in done state
    // ------------------------------------------------------------
    assign avs_waitrequest = (avs_read | avs_write) & (st_r != ST_DONE);
    assign wr_hit = avs_write & (st_r == ST_DONE);
    assign wdata = avs_writedata[7:0];

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ST_IDLE: begin
                if (avs_read | avs_write) begin
                    st_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                st_nxt = ST_DONE;
            end
            ST_DONE: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // register writes and control pulses
    // ------------------------------------------------------------
    always_comb begin
        l_nxt = l_r;
        g_nxt = g_r;
        c_nxt = c_r;
        d_nxt = d_r;
        halt_nxt = 1'b0;
        idle_nxt = 1'b0;
        if (wr_hit) begin
            unique case (avs_address)
                ADDR_L_DATA: l_nxt.data = merge_byte(l_r.data, wdata, avs_byteenable[0]);
                ADDR_L_CFG: l_nxt.cfg = merge_byte(l_r.cfg, wdata, avs_byteenable[0]);
                ADDR_G_DATA: begin
                    g_nxt.data = merge_byte(g_r.data, wdata, avs_byteenable[0]);
                    halt_nxt = avs_byteenable[0] & wdata[G_BIT_HALT];
                    idle_nxt = avs_byteenable[0] & wdata[G_BIT_IDLE];
                end
                ADDR_G_CFG: g_nxt.cfg = merge_byte(g_r.cfg, wdata, avs_byteenable[0]);
                ADDR_C_DATA: c_nxt.data = merge_byte(c_r.data, wdata, avs_byteenable[0]);
                ADDR_C_CFG: c_nxt.cfg = merge_byte(c_r.cfg, wdata, avs_byteenable[0]);
                ADDR_D_DATA: d_nxt = merge_byte(d_r, wdata, avs_byteenable[0]);
                default: begin
                end
            endcase
        end
        // halt and idle bits are strobes, not stored states
        g_nxt.data[G_BIT_HALT] = 1'b0;
        g_nxt.data[G_BIT_IDLE] = 1'b0;
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = UNMAPPED_READ;
        if (avs_read & (st_r == ST_WAIT)) begin
            unique case (avs_address)
                ADDR_L_DATA: rdata_nxt[7:0] = l_r.data;
                ADDR_L_CFG: rdata_nxt[7:0] = l_r.cfg;
                ADDR_L_PIN: rdata_nxt[7:0] = l_sync;
                ADDR_G_DATA: rdata_nxt[7:0] = g_r.data & G_DATA_READ_MASK;
                ADDR_G_CFG: rdata_nxt[7:0] = g_r.cfg;
                ADDR_G_PIN: rdata_nxt[7:0] = g_sync;
                ADDR_C_DATA: rdata_nxt[7:0] = c_r.data;
                ADDR_C_CFG: rdata_nxt[7:0] = c_r.cfg;
                ADDR_C_PIN: rdata_nxt[7:0] = c_sync;
                ADDR_D_DATA: rdata_nxt[7:0] = d_r;
                ADDR_I_PIN: rdata_nxt[7:0] = i_sync;
                ADDR_STATUS: rdata_nxt[1:0] = {crystal_option, supervision_error};
                default: rdata_nxt = UNMAPPED_READ;
            endcase
        end else if (st_r == ST_DONE) begin
            rdata_nxt = rdata_r;
        end
    end
    assign avs_readdata = rdata_r;

    // ------------------------------------------------------------
    // g7 rising edge detect for halt exit
    // ------------------------------------------------------------
    always_comb begin
        g7_prev_nxt = g_sync[G_BIT_OSC];
        wake_nxt = ~crystal_option & g_sync[G_BIT_OSC] & ~g7_prev_r;
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            l_r <= '{cfg: PORT_RESET, data: PORT_RESET};
            g_r <= '{cfg: PORT_RESET, data: PORT_RESET};
            c_r <= '{cfg: PORT_RESET, data: PORT_RESET};
            d_r <= D_RESET;
            halt_r <= 1'b0;
            idle_r <= 1'b0;
            wake_r <= 1'b0;
            g7_prev_r <= 1'b0;
            st_r <= ST_IDLE;
            rdata_r <= UNMAPPED_READ;
        end else begin
            l_r <= l_nxt;
            g_r <= g_nxt;
            c_r <= c_nxt;
            d_r <= d_nxt;
            halt_r <= halt_nxt;
            idle_r <= idle_nxt;
            wake_r <= wake_nxt;
            g7_prev_r <= g7_prev_nxt;
            st_r <= st_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // special port g controls
    // ------------------------------------------------------------
    assign halt_request = halt_r;
    assign idle_request = idle_r;
    assign halt_exit_wakeup = wake_r;
    assign serial_alt_phase = g_r.cfg[G_BIT_ALTSK];
    assign halt_startup_delay_enable = g_r.cfg[G_BIT_DLY] & ~crystal_option;

    // ------------------------------------------------------------
    // port l and c pads, port l alternates
    // ------------------------------------------------------------
    always_comb begin
        l_pin_out = l_pad.out;
        l_pin_oe = l_pad.oe;
        l_pin_pull = l_pad.pull;
        if (usart_transmit_en) begin
            l_pin_out[2] = usart_transmit_pin;
            l_pin_oe[2] = 1'b1;
        end
        c_pin_out = c_pad.out;
        c_pin_oe = c_pad.oe;
        c_pin_pull = c_pad.pull;
    end
    assign usart_external_clock = l_sync[1];
    assign usart_receive_pin = l_sync[3];
    assign timer2_input_a = l_sync[4];
    assign timer2_input_b = l_sync[5];
    assign timer3_input_a = l_sync[6];
    assign timer3_input_b = l_sync[7];
    assign multi_input_wakeup = l_sync;

    // ------------------------------------------------------------
    // port g pads with dedicated and alternate pins
    // ------------------------------------------------------------
    always_comb begin
        g_pin_out = g_pad.out;
        g_pin_oe = g_pad.oe;
        g_pin_pull = g_pad.pull;
        g_pin_out[G_BIT_SI] = 1'b0;
        g_pin_oe[G_BIT_SI] = 1'b0;
        g_pin_pull[G_BIT_SI] = 1'b0;
        g_pin_out[G_BIT_ERR] = 1'b0;
        g_pin_oe[G_BIT_ERR] = supervision_error;
        g_pin_pull[G_BIT_ERR] = 1'b0;
        g_pin_out[G_BIT_OSC] = crystal_option & oscillator_clock_in;
        g_pin_oe[G_BIT_OSC] = crystal_option;
        g_pin_pull[G_BIT_OSC] = 1'b0;
        if (serial_shift_clock_oe) begin
            g_pin_out[G_BIT_SK] = serial_shift_clock_out;
            g_pin_oe[G_BIT_SK] = 1'b1;
        end
        if (serial_data_out_en) begin
            g_pin_out[G_BIT_SO] = serial_data_out;
            g_pin_oe[G_BIT_SO] = 1'b1;
        end
        if (timer1_io_en) begin
            g_pin_out[G_BIT_T1IO] = timer1_io_out;
            g_pin_oe[G_BIT_T1IO] = 1'b1;
        end
    end
    assign serial_data_in = g_sync[G_BIT_SI];
    assign serial_shift_clock_in = g_sync[G_BIT_SK];
    assign timer1_io = g_sync[G_BIT_T1IO];
    assign timer1_capture_in = g_sync[G_BIT_T1CAP];
    assign external_interrupt_in = g_sync[G_BIT_INT];

    // ------------------------------------------------------------
    // port i comparator taps and port d
    // ------------------------------------------------------------
    assign comparator1_negative_input = i_sync[1];
    assign comparator1_positive_input = i_sync[2];
    assign comparator1_output = i_sync[3];
    assign comparator2_negative_input = i_sync[4];
    assign comparator2_positive_input = i_sync[5];
    assign comparator2_output = i_sync[6];
    assign d_pin_out = d_r;
endmodule : pio_port_io

// *** shared/pio_pkg.sv ***
package pio_pkg;
    // ------------------------------------------------------------
    // register map (word aligned byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_L_DATA = 8'h00;
    localparam logic [7:0] ADDR_L_CFG = 8'h04;
    localparam logic [7:0] ADDR_L_PIN = 8'h08;
    localparam logic [7:0] ADDR_G_DATA = 8'h0C;
    localparam logic [7:0] ADDR_G_CFG = 8'h10;
    localparam logic [7:0] ADDR_G_PIN = 8'h14;
    localparam logic [7:0] ADDR_C_DATA = 8'h18;
    localparam logic [7:0] ADDR_C_CFG = 8'h1C;
    localparam logic [7:0] ADDR_C_PIN = 8'h20;
    localparam logic [7:0] ADDR_D_DATA = 8'h24;
    localparam logic [7:0] ADDR_I_PIN = 8'h28;
    localparam logic [7:0] ADDR_STATUS = 8'h2C;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int G_BIT_HALT = 7;
    localparam int G_BIT_IDLE = 6;
    localparam int G_BIT_DLY = 7;
    localparam int G_BIT_ALTSK = 6;
    localparam int G_BIT_ERR = 1;
    localparam int G_BIT_OSC = 7;
    localparam int G_BIT_SI = 6;
    localparam int G_BIT_SK = 5;
    localparam int G_BIT_SO = 4;
    localparam int G_BIT_T1IO = 3;
    localparam int G_BIT_T1CAP = 2;
    localparam int G_BIT_INT = 0;
    localparam logic [7:0] G_DATA_READ_MASK = 8'h3F;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [7:0] D_RESET = 8'hFF;
    localparam logic [1:0] WAIT_CYCLES = 2'h1;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull;
    } pio_pad_t;

    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] data;
    } pio_port_regs_t;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} pio_bus_state_t;
endpackage : pio_pkg

// *** verilog/pio_pad_decode.sv ***
`timescale 1ns/10ps
module pio_pad_decode
    import pio_pkg::*;
(
    input wire pio_port_regs_t regs, // config and data of one port
    output pio_pad_t pad // pad drive controls
);
    // ------------------------------------------------------------
    // per-bit decode of config and data
    // ------------------------------------------------------------
    always_comb begin
        pad.oe = regs.cfg;
        pad.out = regs.data;
        pad.pull = ~regs.cfg & regs.data;
    end
endmodule : pio_pad_decode

// *** verilog/pio_sync2.sv ***
`timescale 1ns/10ps
module pio_sync2
    import pio_pkg::*;
(
    input wire logic clk, // clock
    input wire logic reset, // synchronous reset
    input wire logic [7:0] d, // raw pin levels
    output logic [7:0] q // synchronised levels
);
    logic [7:0] s1_r;
    logic [7:0] s2_r;
    logic [7:0] s1_nxt;
    logic [7:0] s2_nxt;

    // ------------------------------------------------------------
    // two-stage synchroniser
    // ------------------------------------------------------------
    always_comb begin
        s1_nxt = d;
        s2_nxt = s1_r;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s1_r <= PORT_RESET;
            s2_r <= PORT_RESET;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
        end
    end

    assign q = s2_r;
endmodule : pio_sync2

// *** tb/pio_pins_model.sv ***
`timescale 1ns/10ps
module pio_pins_model
    import pio_pkg::*;
(
    input wire logic clk, // clock
    input wire logic [7:0] out, // pad value
    input wire logic [7:0] oe, // pad drive
    input wire logic [7:0] pull, // pad weak pull-up
    input wire logic [7:0] ext, // outside drive value
    input wire logic [7:0] ext_en, // outside drive on
    output logic [7:0] pin // resolved level
);
    logic [7:0] flt_r = 8'h00;
    // undriven, unpulled lines wander every cycle
    always_ff @(posedge clk) flt_r <= ~flt_r;
    // pad wins, then outside driver, then pull-up, else floating
    assign pin = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pull | flt_r));
endmodule : pio_pins_model

// *** tb/pio_port_io_sva.sv ***
`timescale 1ns/10ps
module pio_port_io_chk
    import pio_pkg::*;
(
    input wire logic clk, // clock
    input wire logic reset, // sync reset
    input wire logic [7:0] avs_address, // address
    input wire logic avs_read, // read
    input wire logic avs_write, // write
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // lanes
    input wire logic [31:0] avs_readdata, // read data
    input wire logic avs_waitrequest, // stall
    input wire logic [7:0] c_pin_oe, // c drive
    input wire logic [7:0] c_pin_pull, // c pull-up
    input wire logic [7:0] g_pin_oe, // g drive
    input wire logic [7:0] g_pin_out, // g value
    input wire logic [7:0] l_pin_in, // l pins
    input wire logic [7:0] multi_input_wakeup, // wake-up
    input wire logic crystal_option, // oscillator option
    input wire logic oscillator_clock_in, // oscillator clock
    input wire logic supervision_error, // error in
    input wire logic halt_request, // halt pulse
    input wire logic idle_request, // idle pulse
    input wire logic halt_startup_delay_enable // delay level
);
    // accepted write to port g data
    wire wr_g = avs_write && !avs_waitrequest && avs_address == ADDR_G_DATA && avs_byteenable[0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    chk_bus_answer_time: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest [*2] ##1 !avs_waitrequest)
        else $error("bus answer not in third cycle");
    chk_halt_cause: assert property (halt_request |-> $past(wr_g && avs_writedata[G_BIT_HALT]))
        else $error("halt without write");
    chk_halt_pulse: assert property (wr_g && avs_writedata[G_BIT_HALT] |=> halt_request ##1 !halt_request)
        else $error("halt pulse wrong");
    chk_idle_pulse: assert property (wr_g && avs_writedata[G_BIT_IDLE] |=> idle_request ##1 !idle_request)
        else $error("idle pulse wrong");
    chk_g_read_zero: assert property (avs_read && !avs_waitrequest && avs_address == ADDR_G_DATA
        |-> avs_readdata[7:6] == 2'h0)
        else $error("g data bits 7:6 not zero");
    chk_pad_decode: assert property ((c_pin_oe & c_pin_pull) == 8'h00)
        else $error("pull-up on driven pin");
    chk_delay_option: assert property (halt_startup_delay_enable |-> !crystal_option)
        else $error("start-up delay with crystal");
    chk_osc_out: assert property (crystal_option |-> g_pin_oe[G_BIT_OSC] && g_pin_out[G_BIT_OSC] == oscillator_clock_in)
        else $error("g7 not oscillator out");
    chk_err_out: assert property (supervision_error [*2] |-> g_pin_oe[G_BIT_ERR] && !g_pin_out[G_BIT_ERR])
        else $error("g1 not driving error");
    chk_pin_sync: assert property (!$past(reset) && !$past(reset, 2) |-> multi_input_wakeup == $past(l_pin_in, 2))
        else $error("wake-up not two-stage synced");
endmodule : pio_port_io_chk
bind pio_port_io pio_port_io_chk u_chk (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .c_pin_oe, .c_pin_pull, .g_pin_oe, .g_pin_out, .l_pin_in,
    .multi_input_wakeup, .crystal_option, .oscillator_clock_in, .supervision_error, .halt_request, .idle_request,
    .halt_startup_delay_enable);

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench
    import pio_pkg::*;
();
    logic clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0] avs_byteenable = 4'hF;
    logic avs_waitrequest;
    logic [7:0] l_pin_in, l_pin_out, l_pin_oe, l_pin_pull, g_pin_in, g_pin_out, g_pin_oe, g_pin_pull;
    logic [7:0] c_pin_in, c_pin_out, c_pin_oe, c_pin_pull, d_pin_out, multi_input_wakeup;
    logic [7:0] i_pin_in = 8'h00, l_ext = 8'h00, g_ext = 8'h00, c_ext = 8'h00, l_en = 8'h00, g_en = 8'h00, c_en = 8'h00;
    logic crystal_option = 1'b0, oscillator_clock_in = 1'b0, supervision_error = 1'b0;
    logic serial_shift_clock_out = 1'b0, serial_shift_clock_oe = 1'b0, serial_data_out = 1'b0, serial_data_out_en = 1'b0;
    logic timer1_io_out = 1'b0, timer1_io_en = 1'b0, usart_transmit_pin = 1'b0, usart_transmit_en = 1'b0;
    logic halt_request, idle_request, halt_exit_wakeup, halt_startup_delay_enable, serial_alt_phase;
    logic serial_data_in, serial_shift_clock_in, timer1_io, timer1_capture_in, external_interrupt_in;
    logic usart_external_clock, usart_receive_pin, timer2_input_a, timer2_input_b, timer3_input_a, timer3_input_b;
    logic comparator1_negative_input, comparator1_positive_input, comparator1_output;
    logic comparator2_negative_input, comparator2_positive_input, comparator2_output;
    logic [7:0] rr[6] = '{ADDR_L_DATA, ADDR_L_CFG, ADDR_G_DATA, ADDR_G_CFG, ADDR_C_DATA, ADDR_C_CFG};
    logic [7:0] pa[2][3] = '{'{ADDR_L_DATA, ADDR_L_CFG, ADDR_L_PIN}, '{ADDR_C_DATA, ADDR_C_CFG, ADDR_C_PIN}};
    logic [7:0] gv[4] = '{8'hC0, 8'h80, 8'h40, 8'h3F};
    logic [7:0] pv[2] = '{8'hA5, 8'h5A};
    int errors = 0, check_count = 0, cycles = 0, n;
    pio_port_io dut (.*);
    pio_pins_model u_l (.clk, .out(l_pin_out), .oe(l_pin_oe), .pull(l_pin_pull), .ext(l_ext), .ext_en(l_en), .pin(l_pin_in));
    pio_pins_model u_g (.clk, .out(g_pin_out), .oe(g_pin_oe), .pull(g_pin_pull), .ext(g_ext), .ext_en(g_en), .pin(g_pin_in));
    pio_pins_model u_c (.clk, .out(c_pin_out), .oe(c_pin_oe), .pull(c_pin_pull), .ext(c_ext), .ext_en(c_en), .pin(c_pin_in));
    // ------------------------------------------------------------
    // clock, timeout, helpers
    // ------------------------------------------------------------
    initial forever #2 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            results();
        end
    end
    task automatic results;
        if (errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        // only the hang guard ends a wait
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd
    task automatic rst_chk;
        chk(d_pin_out, D_RESET);
        chk({l_pin_oe, l_pin_pull, c_pin_oe, c_pin_pull}, 32'h0);
        chk({g_pin_oe, g_pin_pull} & 16'hFDFD, 32'h0);
        foreach (rr[k]) rd(rr[k], {24'h0, PORT_RESET});
    endtask : rst_chk
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rst_chk();
        l_en <= 8'h40;
        c_en <= 8'h40;
        l_ext <= 8'h40;
        c_ext <= 8'h40;
        foreach (pa[p]) begin
            wr(pa[p][1], 32'h0F);
            wr(pa[p][0], 32'h35);
            #1 chk(p ? {c_pin_oe, c_pin_out & c_pin_oe, c_pin_pull} : {l_pin_oe, l_pin_out & l_pin_oe, l_pin_pull}, 32'h0F0530);
            wr(pa[p][1], 32'h8F);
            #1 chk(p ? {c_pin_oe, c_pin_out & c_pin_oe, c_pin_pull} : {l_pin_oe, l_pin_out & l_pin_oe, l_pin_pull}, 32'h8F0530);
            rd(pa[p][2], 32'h75);
            avs_byteenable <= 4'hE;
            wr(pa[p][0], 32'hFF);
            avs_byteenable <= 4'hF;
            rd(pa[p][0], 32'h35);
            rd(pa[p][1], 32'h8F);
        end
        foreach (gv[k]) begin
            wr(ADDR_G_DATA, gv[k]);
            #1 chk({halt_request, idle_request}, gv[k][7:6]);
        end
        rd(ADDR_G_DATA, 32'h3F);
        chk(g_pin_pull & 8'h3D, 8'h3D);
        wr(ADDR_G_CFG, 32'hC0);
        #1 chk({serial_alt_phase, halt_startup_delay_enable}, 2'h3);
        rd(ADDR_G_CFG, 32'hC0);
        crystal_option <= 1'b1;
        oscillator_clock_in <= 1'b1;
        @(posedge clk);
        #1 chk({halt_startup_delay_enable, g_pin_oe[7], g_pin_out[7]}, 3'h3);
        @(posedge clk);
        crystal_option <= 1'b0;
        g_en <= 8'h80;
        repeat (4) @(posedge clk);
        g_ext <= 8'h80;
        for (n = 0; n < 8 && halt_exit_wakeup !== 1'b1; n++) @(posedge clk);
        chk(halt_exit_wakeup, 1'b1);
        supervision_error <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({g_pin_oe[1], g_pin_out[1]}, 2'h2);
        rd(ADDR_STATUS, 32'h1);
        supervision_error <= 1'b0;
        rd(8'hFC, UNMAPPED_READ);
        wr(ADDR_D_DATA, 32'h3C);
        #1 chk(d_pin_out, 8'h3C);
        // reset again in mid-run
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rst_chk();
        l_en <= 8'hFF;
        g_en <= 8'h7D;
        foreach (pv[k]) begin
            l_ext <= pv[k];
            g_ext <= pv[k];
            i_pin_in <= pv[k];
            repeat (3) @(posedge clk);
            chk(multi_input_wakeup, pv[k]);
            chk({timer3_input_b, timer3_input_a, timer2_input_b, timer2_input_a, usart_receive_pin,
                usart_external_clock}, {pv[k][7:3], pv[k][1]});
            chk({serial_data_in, serial_shift_clock_in, timer1_io, timer1_capture_in, external_interrupt_in},
                {pv[k][6:5], pv[k][3:2], pv[k][0]});
            chk({comparator2_output, comparator2_positive_input, comparator2_negative_input, comparator1_output,
                comparator1_positive_input, comparator1_negative_input}, pv[k][6:1]);
            rd(ADDR_I_PIN, pv[k]);
        end
        serial_shift_clock_oe <= 1'b1;
        serial_shift_clock_out <= 1'b1;
        serial_data_out_en <= 1'b1;
        timer1_io_en <= 1'b1;
        timer1_io_out <= 1'b1;
        usart_transmit_en <= 1'b1;
        usart_transmit_pin <= 1'b1;
        @(posedge clk);
        #1 chk({g_pin_oe[5:3], g_pin_out[5:3], l_pin_oe[2], l_pin_out[2]}, 8'hF7);
        results();
    end
endmodule : testbench
